// *** rtl/wdtled_pkg.sv ***
// constants and types for the watchdog timer with status led
`default_nettype none
package wdtled_pkg;
   // gpio configuration register field positions
   localparam int CFG_DIR_BIT      = 0;
   localparam int CFG_POL_BIT      = 1;
   localparam int CFG_FUNC_LO      = 3;
   localparam int CFG_FUNC_HI      = 4;
   localparam int CFG_OTYPE_BIT    = 7;
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_ALT  = 2'h1;
   localparam logic [7:0] GPIO_CFG_RESET = 8'h01;
   // watchdog control register bits
   localparam int CTRL_STATUS_BIT  = 0;
   localparam int CTRL_TOGGLE_BIT  = 1;
   localparam int CTRL_FORCE_BIT   = 2;
   // watchdog config register bits
   localparam int CFG_KBD_EN_BIT   = 0;
   localparam int CFG_MOUSE_EN_BIT = 1;
   localparam int CFG_GAME_EN_BIT  = 2;
   localparam int CFG_TOGGLE_TO_BIT = 3;
   localparam int CFG_IRQ_LO       = 4;
   localparam int CFG_IRQ_HI       = 7;
   // timeout units register: msb selects seconds
   localparam int UNITS_SEC_BIT    = 7;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [15:0] GAME_PORT_ADDR = 16'h0201;
   // timing
   localparam longint CLK_HZ       = 100000000;
   localparam longint TICK_PERIOD_S = 1;
   localparam longint CYCLES_PER_SEC = CLK_HZ * TICK_PERIOD_S;
   localparam int SECS_PER_MIN     = 60;
   localparam int BLINK_HALF_DIV   = 2;
   // register reset values
   localparam logic [7:0] UNITS_RESET  = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   // led data bit positions in the two gpio data groups
   localparam int LED_A_DATA_BIT   = 3;
   localparam int LED_B_DATA_BIT   = 1;
   typedef enum logic [1:0] {
      TMR_IDLE    = 2'b00,
      TMR_COUNT   = 2'b01,
      TMR_EXPIRED = 2'b10
   } wdtled_state_t;
endpackage
`default_nettype wire

// *** rtl/wdtled_prescaler.sv ***
// prescaler making second, minute and 1 hz blink phase ticks
`default_nettype none
module wdtled_prescaler #(
   parameter longint CYCLES_PER_SEC = wdtled_pkg::CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // ticks
   output logic      secTick,
   output logic      minTick,
   output logic      blinkPhase
);
   localparam longint HALF = CYCLES_PER_SEC / wdtled_pkg::BLINK_HALF_DIV;
   logic [31:0] cycCount;
   logic [5:0]  secCount;
   logic        halfTick;

   assign halfTick = (cycCount == 32'(HALF - 1)) || (cycCount == 32'(CYCLES_PER_SEC - 1));

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cycCount <= 32'h0;
      end else if (cycCount == 32'(CYCLES_PER_SEC - 1)) begin
         cycCount <= 32'h0;
      end else begin
         cycCount <= cycCount + 32'h1;
      end
   end

   // blink phase flips every half second: 1 hz, 50 percent duty
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         blinkPhase <= 1'h0;
      end else if (halfTick) begin
         blinkPhase <= ~blinkPhase;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         secTick  <= 1'h0;
         minTick  <= 1'h0;
         secCount <= 6'h0;
      end else begin
         secTick <= (cycCount == 32'(CYCLES_PER_SEC - 1));
         minTick <= (cycCount == 32'(CYCLES_PER_SEC - 1)) && (secCount == 6'(wdtled_pkg::SECS_PER_MIN - 1));
         if (cycCount == 32'(CYCLES_PER_SEC - 1)) begin
            secCount <= (secCount == 6'(wdtled_pkg::SECS_PER_MIN - 1)) ? 6'h0 : secCount + 6'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/wdtled_gpio_pin.sv ***
// one gpio pin with a selectable alternate output function
`default_nettype none
module wdtled_gpio_pin (
   // configuration and data
   input  wire logic [7:0] pinCfg,
   input  wire logic       dataBit,
   input  wire logic       altValue,
   input  wire logic       pinIn,
   // pin
   output logic            pinOut,
   output logic            pinOe,
   output logic            pinLevel
);
   logic altSel;
   logic isOut;
   logic value;

   assign altSel = pinCfg[wdtled_pkg::CFG_FUNC_HI:wdtled_pkg::CFG_FUNC_LO] == wdtled_pkg::FUNC_ALT;
   // alternate function forces output direction, direction bit ignored
   assign isOut  = altSel | ~pinCfg[wdtled_pkg::CFG_DIR_BIT];
   assign value  = (altSel ? altValue : dataBit) ^ pinCfg[wdtled_pkg::CFG_POL_BIT];
   // open drain only pulls low; high level comes from the pull-up
   assign pinOut = value;
   assign pinOe  = isOut & (~pinCfg[wdtled_pkg::CFG_OTYPE_BIT] | ~value);
   assign pinLevel = pinIn ^ pinCfg[wdtled_pkg::CFG_POL_BIT];
endmodule
`default_nettype wire

// *** rtl/wdtled_top.sv ***
// watchdog timer with sticky status bit and blinking power led
//
// Summary of operation
// - time-out of 1 to 255 seconds or minutes
// - units register msb selects seconds or minutes
// - reload zero disables; resets to zero
// - nonzero reload write restarts countdown
// - at zero, counter halts, status set
// - host may set or clear status; a hardware set in the same cycle wins over a clear
// - keyboard, mouse, game-port access restart sources
// - enabled source reloads and clears status
// - rise pulse on status rising edge; status level on chosen irq channel
// - mapped irq line follows status level
// - force bit zeros count, sets status, self-clears
// - status available as alternate output, two pins
// - led pin direction comes from its config input; nothing here resets it
// - data bit turns led on or off
// - blinking only with led alternate function
// - toggle bit blinks led 1 hz whatever the status
// - toggle-on-timeout blinks led while status set
// - otherwise led steady at its data value
// - pin polarity bit inverts led output
// - output type bit selects open drain
// - alternate function forces pin direction
`default_nettype none
module wdtled_top #(
   parameter longint CYCLES_PER_SEC = wdtled_pkg::CYCLES_PER_SEC,
   parameter int     IRQ_CHANNELS   = 16
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   // watchdog registers: value plus write strobe
   input  wire logic [7:0]              reloadValueIn,
   input  wire logic                    reloadValueWr,
   input  wire logic [7:0]              timeoutUnitsIn,
   input  wire logic                    timeoutUnitsWr,
   input  wire logic [7:0]              configIn,
   input  wire logic                    configWr,
   input  wire logic [7:0]              controlIn,
   input  wire logic                    controlWr,
   // register readback
   output logic [7:0]                   reloadValue,
   output logic [7:0]                   timeoutUnits,
   output logic [7:0]                   watchdogConfig,
   output logic [7:0]                   watchdogControl,
   output logic [7:0]                   countValue,
   // restart sources
   input  wire logic                    kbdIrq,
   input  wire logic                    mouseIrq,
   input  wire logic                    ioAccess,
   input  wire logic [15:0]             ioAddr,
   // interrupt
   output logic [IRQ_CHANNELS-1:0]      irqOut,
   output logic                         timeoutRise,
   // gpio configuration and data
   input  wire logic [7:0]              statusPinACfg,
   input  wire logic [7:0]              statusPinBCfg,
   input  wire logic [7:0]              ledPinACfg,
   input  wire logic [7:0]              ledPinBCfg,
   input  wire logic [7:0]              gpioGroup1Data,
   input  wire logic [7:0]              gpioGroup6Data,
   // pins
   input  wire logic [3:0]              pinIn,
   output logic [3:0]                   pinOut,
   output logic [3:0]                   pinOe,
   output logic [3:0]                   pinLevel
);
   localparam int LED_A_DATA_BIT = wdtled_pkg::LED_A_DATA_BIT;
   localparam int LED_B_DATA_BIT = wdtled_pkg::LED_B_DATA_BIT;

   wdtled_pkg::wdtled_state_t state;
   wdtled_pkg::wdtled_state_t next_state;
   logic [7:0] count;
   logic       timeoutStatus;
   logic       toggleLed;
   logic       statusDly;
   logic       secTick;
   logic       minTick;
   logic       blinkPhase;
   logic       unitTick;
   logic       restart;
   logic       forceNow;
   logic       reachZero;
   logic       blinkOn;

   wdtled_prescaler #(
      .CYCLES_PER_SEC(CYCLES_PER_SEC)
   ) uPrescaler (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .secTick    (secTick),
      .minTick    (minTick),
      .blinkPhase (blinkPhase)
   );

   // register storage
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reloadValue    <= wdtled_pkg::RELOAD_RESET;
         timeoutUnits   <= wdtled_pkg::UNITS_RESET;
         watchdogConfig <= wdtled_pkg::CONFIG_RESET;
         toggleLed      <= 1'h0;
      end else begin
         if (reloadValueWr) begin
            reloadValue <= reloadValueIn;
         end
         if (timeoutUnitsWr) begin
            timeoutUnits <= timeoutUnitsIn;
         end
         if (configWr) begin
            watchdogConfig <= configIn;
         end
         if (controlWr) begin
            toggleLed <= controlIn[wdtled_pkg::CTRL_TOGGLE_BIT];
         end
      end
   end

   // restart sources, each gated by its own enable
   assign restart = (kbdIrq & watchdogConfig[wdtled_pkg::CFG_KBD_EN_BIT])
                  | (mouseIrq & watchdogConfig[wdtled_pkg::CFG_MOUSE_EN_BIT])
                  | (ioAccess && ioAddr == wdtled_pkg::GAME_PORT_ADDR
                     && watchdogConfig[wdtled_pkg::CFG_GAME_EN_BIT]);

   assign forceNow = controlWr & controlIn[wdtled_pkg::CTRL_FORCE_BIT];
   // unit tick: second ticks directly, or minute ticks when msb clear
   assign unitTick = timeoutUnits[wdtled_pkg::UNITS_SEC_BIT] ? secTick : minTick;
   assign reachZero = (state == wdtled_pkg::TMR_COUNT) && unitTick && (count == 8'h01);

   // a restart over a zero reload must not wake the counter
   function automatic logic start_count(
      input logic       writeStrobe,
      input logic [7:0] writeValue,
      input logic       restartEvent,
      input logic [7:0] heldValue
   );
      return (writeStrobe && writeValue != 8'h00) || (restartEvent && heldValue != 8'h00);
   endfunction

   always_comb begin
      next_state = state;
      case (state)
         wdtled_pkg::TMR_IDLE: begin
            if (start_count(reloadValueWr, reloadValueIn, restart, reloadValue)) begin
               next_state = wdtled_pkg::TMR_COUNT;
            end
         end
         wdtled_pkg::TMR_COUNT: begin
            if (reachZero) begin
               next_state = wdtled_pkg::TMR_EXPIRED;
            end
         end
         wdtled_pkg::TMR_EXPIRED: begin
            if (start_count(reloadValueWr, reloadValueIn, restart, reloadValue)) begin
               next_state = wdtled_pkg::TMR_COUNT;
            end
         end
         default: next_state = wdtled_pkg::TMR_IDLE;
      endcase
      if (reloadValueWr && reloadValueIn == 8'h00) begin
         next_state = wdtled_pkg::TMR_IDLE;
      end else if (forceNow) begin
         next_state = wdtled_pkg::TMR_EXPIRED;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= wdtled_pkg::TMR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // down counter, 1..255 units
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 8'h00;
      end else if (reloadValueWr) begin
         count <= reloadValueIn;
      end else if (forceNow) begin
         count <= 8'h00;
      end else if (restart) begin
         count <= reloadValue;
      end else if (state == wdtled_pkg::TMR_COUNT && unitTick && count != 8'h00) begin
         count <= count - 8'h01;
      end
   end

   // sticky status: hardware set outranks any clear in the same cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timeoutStatus <= 1'h0;
      end else if (reachZero || forceNow) begin
         timeoutStatus <= 1'h1;
      end else if (controlWr) begin
         timeoutStatus <= controlIn[wdtled_pkg::CTRL_STATUS_BIT];
      end else if (restart) begin
         timeoutStatus <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         statusDly <= 1'h0;
      end else begin
         statusDly <= timeoutStatus;
      end
   end

   assign timeoutRise = timeoutStatus & ~statusDly;

   // channel 0 means unmapped; only the selected nonzero channel carries the status level
   always_comb begin
      irqOut = '0;
      for (int i = 1; i < IRQ_CHANNELS; i++) begin
         if (watchdogConfig[wdtled_pkg::CFG_IRQ_HI:wdtled_pkg::CFG_IRQ_LO] == 4'(i)) begin
            irqOut[i] = timeoutStatus;
         end
      end
   end

   assign countValue      = count;
   // force bit reads zero: it never stores
   assign watchdogControl = {5'h00, 1'h0, toggleLed, timeoutStatus};

   // led blink decision
   assign blinkOn = toggleLed
                  | (watchdogConfig[wdtled_pkg::CFG_TOGGLE_TO_BIT] & timeoutStatus);

   // status output on either of two pins
   wdtled_gpio_pin uStatusA (
      .pinCfg   (statusPinACfg),
      .dataBit  (1'h0),
      .altValue (timeoutStatus),
      .pinIn    (pinIn[0]),
      .pinOut   (pinOut[0]),
      .pinOe    (pinOe[0]),
      .pinLevel (pinLevel[0])
   );

   wdtled_gpio_pin uStatusB (
      .pinCfg   (statusPinBCfg),
      .dataBit  (1'h0),
      .altValue (timeoutStatus),
      .pinIn    (pinIn[1]),
      .pinOut   (pinOut[1]),
      .pinOe    (pinOe[1]),
      .pinLevel (pinLevel[1])
   );

   // plain gpio gives steady data only; blink rides the alternate path
   wdtled_gpio_pin uLedA (
      .pinCfg   (ledPinACfg),
      .dataBit  (gpioGroup1Data[LED_A_DATA_BIT]),
      .altValue (gpioGroup1Data[LED_A_DATA_BIT] & ~(blinkOn & blinkPhase)),
      .pinIn    (pinIn[2]),
      .pinOut   (pinOut[2]),
      .pinOe    (pinOe[2]),
      .pinLevel (pinLevel[2])
   );

   wdtled_gpio_pin uLedB (
      .pinCfg   (ledPinBCfg),
      .dataBit  (gpioGroup6Data[LED_B_DATA_BIT]),
      .altValue (gpioGroup6Data[LED_B_DATA_BIT] & ~(blinkOn & blinkPhase)),
      .pinIn    (pinIn[3]),
      .pinOut   (pinOut[3]),
      .pinOe    (pinOe[3]),
      .pinLevel (pinLevel[3])
   );

   a_force_sets_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
      forceNow |=> timeoutStatus && count == 8'h00)
      else $error("force did not zero count and set status");

   a_zero_halts_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reachZero && !reloadValueWr && !restart
         |=> count == 8'h00 && timeoutStatus && state == wdtled_pkg::TMR_EXPIRED)
      else $error("count did not halt at zero with status set");

   a_reload_restarts: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reloadValueWr && reloadValueIn != 8'h00 && !forceNow
         |=> state == wdtled_pkg::TMR_COUNT && count == $past(reloadValueIn))
      else $error("nonzero reload did not restart countdown");

   a_zero_disables: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reloadValueWr && reloadValueIn == 8'h00 |=> state == wdtled_pkg::TMR_IDLE && !reachZero)
      else $error("zero reload did not disable");

   a_restart_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
      restart && !reachZero && !forceNow && !controlWr && !reloadValueWr
         |=> !timeoutStatus && count == $past(reloadValue))
      else $error("enabled restart did not reload and clear");

   a_host_status_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      controlWr && !reachZero && !forceNow |=> timeoutStatus == $past(controlIn[wdtled_pkg::CTRL_STATUS_BIT]))
      else $error("host status write lost");

   a_irq_follows_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
      watchdogConfig[wdtled_pkg::CFG_IRQ_HI:wdtled_pkg::CFG_IRQ_LO] != 4'h0 |->
         irqOut[watchdogConfig[wdtled_pkg::CFG_IRQ_HI:wdtled_pkg::CFG_IRQ_LO]] == timeoutStatus)
      else $error("irq line does not follow status");

   a_rise_pulse_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
      timeoutRise |=> !timeoutRise && statusDly)
      else $error("rise indication not a single pulse");

   a_led_steady: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !blinkOn && ledPinACfg[wdtled_pkg::CFG_FUNC_HI:wdtled_pkg::CFG_FUNC_LO] == wdtled_pkg::FUNC_ALT |->
         pinOut[2] == (gpioGroup1Data[LED_A_DATA_BIT] ^ ledPinACfg[wdtled_pkg::CFG_POL_BIT]))
      else $error("led not steady at data value");

   a_idle_holds_still: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == wdtled_pkg::TMR_IDLE && reloadValue == 8'h00 && !reloadValueWr && !forceNow |=>
         state == wdtled_pkg::TMR_IDLE)
      else $error("disabled watchdog started");

   a_tick_decrements: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == wdtled_pkg::TMR_COUNT && unitTick && count != 8'h00 && !reloadValueWr && !forceNow && !restart
         |=> count == $past(count) - 8'h01)
      else $error("unit tick did not step the count down");

   a_minutes_skip_seconds: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == wdtled_pkg::TMR_COUNT && !timeoutUnits[wdtled_pkg::UNITS_SEC_BIT] && !minTick
         && !reloadValueWr && !forceNow && !restart |=> count == $past(count))
      else $error("minute count moved without a minute tick");

   a_unmapped_irq_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      watchdogConfig[wdtled_pkg::CFG_IRQ_HI:wdtled_pkg::CFG_IRQ_LO] == 4'h0 |-> irqOut == '0)
      else $error("unmapped watchdog drove an irq line");

   a_alt_forces_output: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ledPinACfg[wdtled_pkg::CFG_FUNC_HI:wdtled_pkg::CFG_FUNC_LO] == wdtled_pkg::FUNC_ALT
         && !ledPinACfg[wdtled_pkg::CFG_OTYPE_BIT] |-> pinOe[2])
      else $error("alternate push pull pin not driven");

   a_gpio_input_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ledPinACfg[wdtled_pkg::CFG_FUNC_HI:wdtled_pkg::CFG_FUNC_LO] != wdtled_pkg::FUNC_ALT
         && ledPinACfg[wdtled_pkg::CFG_DIR_BIT] |-> !pinOe[2])
      else $error("input led pin is driven");

   a_toggle_blinks_led: assert property (@(posedge sys_clk) disable iff (!reset_n)
      toggleLed && blinkPhase
         && ledPinACfg[wdtled_pkg::CFG_FUNC_HI:wdtled_pkg::CFG_FUNC_LO] == wdtled_pkg::FUNC_ALT
         |-> pinOut[2] == ledPinACfg[wdtled_pkg::CFG_POL_BIT])
      else $error("led not in off phase while toggling");

   a_open_drain_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ledPinACfg[wdtled_pkg::CFG_OTYPE_BIT] && pinOut[2] |-> !pinOe[2])
      else $error("open drain led pin drove high");
endmodule
`default_nettype wire

// *** tb/tb_wdtled.sv ***
// self-checking bench for the watchdog timer with status led
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // short second so countdowns and blinking fit in a brief run
   localparam longint CPS = 10;
   logic        sys_clk;
   logic        reset_n;
   logic [7:0]  reloadValueIn, timeoutUnitsIn, configIn, controlIn;
   logic        reloadValueWr, timeoutUnitsWr, configWr, controlWr;
   logic [7:0]  reloadValue, timeoutUnits, watchdogConfig, watchdogControl, countValue;
   logic        kbdIrq, mouseIrq, ioAccess;
   logic [15:0] ioAddr;
   logic [15:0] irqOut;
   logic        timeoutRise;
   logic [7:0]  statusPinACfg, statusPinBCfg, ledPinACfg, ledPinBCfg, gpioGroup1Data, gpioGroup6Data;
   logic [3:0]  pinIn, pinOut, pinOe, pinLevel;
   int          nErrors;
   int          checked;
   int          n;
   int          hi;

   wdtled_top #(.CYCLES_PER_SEC(CPS), .IRQ_CHANNELS(16)) i_wdtled_top (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .reloadValueIn(reloadValueIn), .reloadValueWr(reloadValueWr),
      .timeoutUnitsIn(timeoutUnitsIn), .timeoutUnitsWr(timeoutUnitsWr),
      .configIn(configIn), .configWr(configWr), .controlIn(controlIn), .controlWr(controlWr),
      .reloadValue(reloadValue), .timeoutUnits(timeoutUnits), .watchdogConfig(watchdogConfig),
      .watchdogControl(watchdogControl), .countValue(countValue),
      .kbdIrq(kbdIrq), .mouseIrq(mouseIrq), .ioAccess(ioAccess), .ioAddr(ioAddr),
      .irqOut(irqOut), .timeoutRise(timeoutRise),
      .statusPinACfg(statusPinACfg), .statusPinBCfg(statusPinBCfg),
      .ledPinACfg(ledPinACfg), .ledPinBCfg(ledPinBCfg),
      .gpioGroup1Data(gpioGroup1Data), .gpioGroup6Data(gpioGroup6Data),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel)
   );

   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", nErrors, checked);
      if (nErrors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // sel: 0 reload, 1 units, 2 config, 3 control; strobe lasts one cycle
   task automatic wr(input int sel, input logic [7:0] v);
      @(negedge sys_clk);
      case (sel)
         0: begin reloadValueIn = v; reloadValueWr = 1'h1; end
         1: begin timeoutUnitsIn = v; timeoutUnitsWr = 1'h1; end
         2: begin configIn = v; configWr = 1'h1; end
         default: begin controlIn = v; controlWr = 1'h1; end
      endcase
      @(negedge sys_clk);
      {reloadValueWr, timeoutUnitsWr, configWr, controlWr} = 4'h0;
   endtask

   // src: 0 keyboard, 1 mouse, 2 io access at addr
   task automatic pulse(input int src, input logic [15:0] addr);
      @(negedge sys_clk);
      case (src)
         0: kbdIrq = 1'h1;
         1: mouseIrq = 1'h1;
         default: begin ioAccess = 1'h1; ioAddr = addr; end
      endcase
      @(negedge sys_clk);
      {kbdIrq, mouseIrq, ioAccess} = 3'h0;
   endtask

   task automatic wait_status(input int lim, output int cnt);
      cnt = 0;
      while (watchdogControl[0] !== 1'h1) begin
         if (cnt >= lim) begin
            nErrors++;
            $display("ERROR at %0t: status never set", $time);
            tally_and_finish();
         end
         @(negedge sys_clk);
         cnt++;
      end
   endtask

   // counts high cycles of a pin over two blink half periods each way
   task automatic high_count(input int idx, output int h);
      h = 0;
      repeat (20) begin
         @(negedge sys_clk);
         if (pinOut[idx] === 1'h1) h++;
      end
   endtask

   initial begin
      nErrors = 0;
      checked = 0;
      reset_n = 1'h0;
      {reloadValueIn, timeoutUnitsIn, configIn, controlIn} = 32'h0;
      {reloadValueWr, timeoutUnitsWr, configWr, controlWr} = 4'h0;
      {kbdIrq, mouseIrq, ioAccess} = 3'h0;
      ioAddr = 16'h0000;
      {statusPinACfg, statusPinBCfg, ledPinACfg, ledPinBCfg} = {4{8'h01}};
      gpioGroup1Data = 8'h00;
      gpioGroup6Data = 8'h00;
      pinIn = 4'ha;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'h1;
      chk(16'(reloadValue), 16'h0000, "reload reset");
      chk(16'(watchdogControl), 16'h0000, "control reset");
      chk(16'(countValue), 16'h0000, "count reset");
      chk(irqOut, 16'h0000, "irq reset");
      chk(16'(pinOe), 16'h0000, "pins input after reset");
      chk(16'(pinLevel), 16'h000a, "pin level");
      wr(1, 8'h80);
      chk(16'(timeoutUnits), 16'h0080, "units readback");
      repeat (40) @(negedge sys_clk);
      chk(16'(watchdogControl[0]), 16'h0001 ^ 16'h0001, "zero reload must not expire");
      wr(0, 8'h03);
      chk(16'(countValue), 16'h0003, "reload starts count");
      chk(16'(reloadValue), 16'h0003, "reload readback");
      wr(3, 8'h01);
      chk(16'(watchdogControl[0]), 16'h0001, "host set status");
      wr(3, 8'h00);
      chk(16'(watchdogControl[0]), 16'h0000, "host clear status");
      wr(2, 8'h50);
      chk(16'(watchdogConfig), 16'h0050, "config readback");
      wr(0, 8'h03);
      wait_status(40, n);
      chk(16'(timeoutRise), 16'h0001, "rise pulse");
      chk(16'(n >= 18 && n <= 34), 16'h0001, "seconds countdown length");
      chk(16'(countValue), 16'h0000, "count at zero");
      chk(irqOut, 16'h0020, "irq on channel five");
      repeat (30) @(negedge sys_clk);
      chk(16'(countValue), 16'h0000, "count halted");
      chk(16'(timeoutRise), 16'h0000, "rise is one pulse");
      chk(irqOut, 16'h0020, "irq follows level");
      wr(2, 8'h00);
      chk(irqOut, 16'h0000, "channel zero unmapped");
      for (int s = 0; s < 3; s++) begin
         pulse(s, 16'h0201);
         chk(16'(watchdogControl[0]), 16'h0001, "disabled source ignored");
      end
      for (int s = 0; s < 3; s++) begin
         wr(2, 8'h00);
         wr(3, 8'h04);
         chk(16'(watchdogControl), 16'h0001, "force sets status, self clears");
         chk(16'(countValue), 16'h0000, "force zeros count");
         wr(2, 8'h50 | (8'h01 << s));
         pulse(s, 16'h0201);
         chk(16'(countValue), 16'h0003, "restart reloads");
         chk(16'(watchdogControl[0]), 16'h0000, "restart clears status");
      end
      wr(3, 8'h04);
      pulse(2, 16'h0202);
      chk(16'(watchdogControl[0]), 16'h0001, "other io address ignored");
      wr(0, 8'h00);
      wr(2, 8'h01);
      pulse(0, 16'h0000);
      repeat (40) @(negedge sys_clk);
      chk(16'(countValue), 16'h0000, "restart with zero reload");
      chk(16'(watchdogControl[0]), 16'h0000, "stays disabled");
      wr(0, 8'hff);
      chk(16'(countValue), 16'h00ff, "largest reload");
      wr(1, 8'h00);
      wr(0, 8'h02);
      wait_status(1300, n);
      // seconds would have expired after about twenty cycles
      chk(16'(n >= 590), 16'h0001, "minute units");
      wr(3, 8'h00);
      // led on pin a: alternate, open drain, non-inverted
      ledPinACfg = 8'h88;
      gpioGroup1Data = 8'h08;
      high_count(2, hi);
      chk(16'(hi), 16'h0014, "led steady on");
      chk(16'(pinOe[2]), 16'h0000, "open drain released");
      gpioGroup1Data = 8'h00;
      @(negedge sys_clk);
      chk(16'({pinOut[2], pinOe[2]}), 16'h0001, "led off drives low");
      gpioGroup1Data = 8'h08;
      wr(3, 8'h02);
      chk(16'(watchdogControl), 16'h0002, "toggle bit stored");
      high_count(2, hi);
      chk(16'(hi), 16'h000a, "toggle blinks half duty");
      ledPinACfg = 8'h80;
      high_count(2, hi);
      chk(16'(hi), 16'h0014, "plain gpio never blinks");
      wr(3, 8'h00);
      ledPinACfg = 8'h8a;
      @(negedge sys_clk);
      chk(16'(pinOut[2]), 16'h0000, "polarity inverts led");
      chk(16'(pinLevel[2]), 16'h0001, "polarity inverts level");
      ledPinACfg = 8'h09;
      @(negedge sys_clk);
      chk(16'({pinOut[2], pinOe[2]}), 16'h0003, "push pull alt ignores direction");
      // only one led pin carries the alternate function at a time
      ledPinACfg = 8'h01;
      ledPinBCfg = 8'h08;
      gpioGroup6Data = 8'h02;
      @(negedge sys_clk);
      chk(16'({pinOut[3], pinOe[3]}), 16'h0003, "led on pin b");
      ledPinBCfg = 8'h01;
      ledPinACfg = 8'h88;
      wr(2, 8'h08);
      high_count(2, hi);
      chk(16'(hi), 16'h0014, "no blink while status clear");
      wr(3, 8'h01);
      high_count(2, hi);
      chk(16'(hi), 16'h000a, "blink while status set");
      statusPinACfg = 8'h08;
      statusPinBCfg = 8'h08;
      @(negedge sys_clk);
      chk(16'({pinOut[1:0], pinOe[1:0]}), 16'h000f, "status on both pins");
      wr(3, 8'h00);
      chk(16'(pinOut[1:0]), 16'h0000, "status pins follow clear");
      tally_and_finish();
   end
endmodule
`default_nettype wire
